// ===== shared/gpx_pkg.sv
// Shared constants for the serial GPIO expander and its serial master
package gpx_pkg;

  // Clock of both ends, in ns
  localparam int CLK_NS = 20;

  // Register offsets, carried in command bits 6:1
  localparam logic [5:0] OFF_PIN_STATE = 6'h00;
  localparam logic [5:0] OFF_OUTPUT_LEVEL = 6'h01;
  localparam logic [5:0] OFF_INPUT_POLARITY_INVERT = 6'h02;
  localparam logic [5:0] OFF_PIN_DIRECTION = 6'h03;
  localparam logic [5:0] OFF_PULLUP_ENABLE = 6'h04;
  localparam logic [5:0] OFF_INPUT_IRQ_ENABLE = 6'h05;
  localparam logic [5:0] OFF_OUTPUT_HIZ_ENABLE = 6'h06;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h07;
  localparam logic [5:0] OFF_RISING_EDGE_SELECT = 6'h08;
  localparam logic [5:0] OFF_FALLING_EDGE_SELECT = 6'h09;
  localparam logic [5:0] OFF_GLITCH_FILTER_ENABLE = 6'h0A;

  // Reset values
  localparam logic [7:0] RST_OUTPUT_LEVEL = 8'hFF;
  localparam logic [7:0] RST_INPUT_POLARITY_INVERT = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PULLUP_ENABLE = 8'h00;
  localparam logic [7:0] RST_INPUT_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_HIZ_ENABLE = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_RISING_EDGE_SELECT = 8'h00;
  localparam logic [7:0] RST_FALLING_EDGE_SELECT = 8'h00;
  localparam logic [7:0] RST_GLITCH_FILTER_ENABLE = 8'hFF;

  // Command byte fields
  localparam int CMD_RD_BIT = 7;
  localparam int CMD_ADDR_HI = 6;
  localparam int CMD_ADDR_LO = 1;

  // Bits per access: command byte then one data byte
  localparam logic [4:0] BITS_CMD = 5'h08;
  localparam logic [4:0] BITS_ALL = 5'h10;

  // Filter: a new level must hold longer than this to count
  localparam int FILT_HOLD_NS = 1075;
  localparam int FILT_HOLD_CYC = (FILT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Pulses shorter than this are always rejected
  localparam int FILT_REJECT_NS = 225;
  localparam int FILT_REJECT_CYC = FILT_REJECT_NS / CLK_NS;
  localparam logic [5:0] FILT_CNT_LAST = 6'(FILT_HOLD_CYC - 1);

  // Reset pin must stay low longer than this
  localparam int RST_PIN_NS = 40;
  localparam int RST_PIN_CYC = (RST_PIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RST_PIN_LAST = 2'(RST_PIN_CYC);

  // Serial clock made by the master
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / 2 / CLK_NS;
  localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

endpackage

// ===== shared/gpx_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// Serial link, reset pin and open-drain interrupt between the two ends
interface gpx_link_if;
  logic sclk; // Serial clock, idles low
  logic cs_n; // Chip select, active low
  logic mosi; // Master to device data
  logic miso; // Device to master data
  logic reset_n; // Reset pin, active low
  logic irq_oe; // Device pulls the interrupt line low
  logic irq_n; // Resolved interrupt line with pull-up

  // Open drain: low while pulled, else the pull-up wins
  assign irq_n = ~irq_oe;

  modport device (
    input sclk, cs_n, mosi, reset_n,
    output miso, irq_oe
  );
  modport host (
    output sclk, cs_n, mosi, reset_n,
    input miso, irq_n
  );
endinterface
`default_nettype wire

// ===== verilog/gpx_device.sv
`timescale 1ns/100ps
`default_nettype none
module gpx_device (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  gpx_link_if.device link,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  output logic [7:0] pullup_en
);

  // Transfer phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_CMD,
    PH_DATA,
    PH_DONE
  } phase_t;

  // Whole state of the device
  typedef struct packed {
    logic [1:0] sclk_s; // Synchroniser, [0] first stage
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic [1:0] rstp_s;
    logic [7:0] in_s1; // Pin synchroniser stage one
    logic [7:0] in_s2; // Pin synchroniser stage two
    logic sclk_d; // Last synchronised serial clock
    phase_t phase;
    logic [4:0] bitn; // Bits taken in this access
    logic [7:0] shift; // Incoming bits
    logic rd; // Current access is a read
    logic [5:0] addr; // Current register offset
    logic [7:0] miso_sr; // Outgoing bits
    logic miso; // Device data out
    logic [1:0] rcnt; // Reset pin low count
    logic [7:0] output_level;
    logic [7:0] input_polarity_invert;
    logic [7:0] pin_direction;
    logic [7:0] pullup_enable;
    logic [7:0] input_irq_enable;
    logic [7:0] output_hiz_enable;
    logic [7:0] irq_status;
    logic [7:0] rising_edge_select;
    logic [7:0] falling_edge_select;
    logic [7:0] glitch_filter_enable;
    logic [7:0] filt; // Accepted input levels
    logic [7:0][5:0] cnt; // Hold counters per pin
    logic [7:0] snap; // Levels seen at last pin state read
  } state_t;

  state_t cur; // Registered state
  state_t next_cur; // Next state

  // Register read decode
  function automatic logic [7:0] reg_read(input state_t s,
                                          input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      gpx_pkg::OFF_PIN_STATE: begin
        // Outputs show the latch, inputs the optionally inverted pin
        v = (s.pin_direction & (s.in_s2 ^ s.input_polarity_invert)) |
            (~s.pin_direction & s.output_level);
      end
      gpx_pkg::OFF_OUTPUT_LEVEL: v = s.output_level;
      gpx_pkg::OFF_INPUT_POLARITY_INVERT: v = s.input_polarity_invert;
      gpx_pkg::OFF_PIN_DIRECTION: v = s.pin_direction;
      gpx_pkg::OFF_PULLUP_ENABLE: v = s.pullup_enable;
      gpx_pkg::OFF_INPUT_IRQ_ENABLE: v = s.input_irq_enable;
      gpx_pkg::OFF_OUTPUT_HIZ_ENABLE: v = s.output_hiz_enable;
      gpx_pkg::OFF_IRQ_STATUS: v = s.irq_status;
      gpx_pkg::OFF_RISING_EDGE_SELECT: v = s.rising_edge_select;
      gpx_pkg::OFF_FALLING_EDGE_SELECT: v = s.falling_edge_select;
      gpx_pkg::OFF_GLITCH_FILTER_ENABLE: v = s.glitch_filter_enable;
      default: v = 8'h00; // Unmapped offsets read zero
    endcase
    return v;
  endfunction

  // Register defaults, shared by both resets
  function automatic state_t defaults(input state_t s);
    state_t d;
    d = s;
    d.output_level = gpx_pkg::RST_OUTPUT_LEVEL;
    d.pin_direction = gpx_pkg::RST_PIN_DIRECTION;
    d.input_polarity_invert = gpx_pkg::RST_INPUT_POLARITY_INVERT;
    d.pullup_enable = gpx_pkg::RST_PULLUP_ENABLE;
    d.input_irq_enable = gpx_pkg::RST_INPUT_IRQ_ENABLE;
    d.output_hiz_enable = gpx_pkg::RST_OUTPUT_HIZ_ENABLE;
    d.rising_edge_select = gpx_pkg::RST_RISING_EDGE_SELECT;
    d.falling_edge_select = gpx_pkg::RST_FALLING_EDGE_SELECT;
    d.glitch_filter_enable = gpx_pkg::RST_GLITCH_FILTER_ENABLE;
    d.irq_status = gpx_pkg::RST_IRQ_STATUS;
    d.phase = PH_IDLE;
    d.bitn = 5'h00;
    d.miso = 1'b0;
    d.miso_sr = 8'h00;
    return d;
  endfunction

  // Next-state logic
  always_comb begin
    logic rise_sclk; // Serial clock rising edge seen
    logic fall_sclk; // Serial clock falling edge seen
    logic sel; // Chip select active
    logic pin_rd; // Pin state read taken this cycle
    logic [7:0] cmd; // Completed command byte
    logic nf; // Newly accepted level of one pin
    logic ev; // Interrupt event of one pin
    logic clr; // Clear of one pin
    next_cur = cur;
    rise_sclk = 1'b0;
    fall_sclk = 1'b0;
    sel = 1'b0;
    pin_rd = 1'b0;
    cmd = 8'h00;
    nf = 1'b0;
    ev = 1'b0;
    clr = 1'b0;
    if (ce) begin
      // Two-stage synchronisers on every pin
      next_cur.sclk_s = {cur.sclk_s[0], link.sclk};
      next_cur.cs_s = {cur.cs_s[0], link.cs_n};
      next_cur.mosi_s = {cur.mosi_s[0], link.mosi};
      next_cur.rstp_s = {cur.rstp_s[0], link.reset_n};
      next_cur.in_s1 = gpio_in;
      next_cur.in_s2 = cur.in_s1;
      next_cur.sclk_d = cur.sclk_s[1];
      rise_sclk = cur.sclk_s[1] & ~cur.sclk_d;
      fall_sclk = ~cur.sclk_s[1] & cur.sclk_d;
      sel = ~cur.cs_s[1];

      // Serial engine, mode 0: sample on rise, shift out on fall
      if (!sel) begin
        // Select high ends any access, even a cut-short one
        next_cur.phase = PH_IDLE;
        next_cur.bitn = 5'h00;
        next_cur.miso = 1'b0;
      end else begin
        case (cur.phase)
          PH_IDLE: begin
            // Clocking only counts once select is low
            next_cur.phase = PH_CMD;
            next_cur.bitn = 5'h00;
          end
          PH_CMD, PH_DATA: begin
            if (rise_sclk) begin
              next_cur.shift = {cur.shift[6:0], cur.mosi_s[1]};
              next_cur.bitn = cur.bitn + 5'h01;
              if (cur.bitn + 5'h01 == gpx_pkg::BITS_CMD) begin
                cmd = {cur.shift[6:0], cur.mosi_s[1]};
                next_cur.rd = cmd[gpx_pkg::CMD_RD_BIT];
                // Bit 0 plays no part in selecting a register
                next_cur.addr = cmd[gpx_pkg::CMD_ADDR_HI:
                                    gpx_pkg::CMD_ADDR_LO];
                next_cur.miso_sr = reg_read(cur, next_cur.addr);
                pin_rd = cmd[gpx_pkg::CMD_RD_BIT] &&
                         next_cur.addr == gpx_pkg::OFF_PIN_STATE;
                next_cur.phase = PH_DATA;
              end else if (cur.bitn + 5'h01 == gpx_pkg::BITS_ALL) begin
                next_cur.phase = PH_DONE;
                if (!cur.rd) begin
                  // Write commit; read-only offsets ignore it
                  case (cur.addr)
                    gpx_pkg::OFF_OUTPUT_LEVEL:
                      next_cur.output_level = next_cur.shift;
                    gpx_pkg::OFF_INPUT_POLARITY_INVERT:
                      next_cur.input_polarity_invert = next_cur.shift;
                    gpx_pkg::OFF_PIN_DIRECTION:
                      next_cur.pin_direction = next_cur.shift;
                    gpx_pkg::OFF_PULLUP_ENABLE:
                      next_cur.pullup_enable = next_cur.shift;
                    gpx_pkg::OFF_INPUT_IRQ_ENABLE:
                      next_cur.input_irq_enable = next_cur.shift;
                    gpx_pkg::OFF_OUTPUT_HIZ_ENABLE:
                      next_cur.output_hiz_enable = next_cur.shift;
                    gpx_pkg::OFF_RISING_EDGE_SELECT:
                      next_cur.rising_edge_select = next_cur.shift;
                    gpx_pkg::OFF_FALLING_EDGE_SELECT:
                      next_cur.falling_edge_select = next_cur.shift;
                    gpx_pkg::OFF_GLITCH_FILTER_ENABLE:
                      next_cur.glitch_filter_enable = next_cur.shift;
                    default: begin
                      // Unmapped or read-only: dropped
                    end
                  endcase
                end
              end
            end
            if (fall_sclk && cur.phase == PH_DATA && cur.rd) begin
              // First fall after the command shows bit 7
              next_cur.miso = cur.miso_sr[7];
              next_cur.miso_sr = {cur.miso_sr[6:0], 1'b0};
            end
          end
          PH_DONE: begin
            // Extra clocks are ignored until select rises
            next_cur.miso = 1'b0;
          end
          default: next_cur.phase = PH_IDLE;
        endcase
      end

      // Pin state read keeps a snapshot for return-to-level clears
      if (pin_rd) begin
        next_cur.snap = cur.in_s2;
      end

      // Input filter and interrupt events, per pin
      for (int i = 0; i < 8; i++) begin
        nf = cur.filt[i];
        if (cur.in_s2[i] == cur.filt[i]) begin
          next_cur.cnt[i] = 6'h00; // Pulse ended early: rejected
        end else if (!cur.glitch_filter_enable[i]) begin
          nf = cur.in_s2[i];
          next_cur.cnt[i] = 6'h00;
        end else if (cur.cnt[i] == gpx_pkg::FILT_CNT_LAST) begin
          // Held long enough; anything short never reaches here
          nf = cur.in_s2[i];
          next_cur.cnt[i] = 6'h00;
        end else begin
          next_cur.cnt[i] = cur.cnt[i] + 6'h01;
        end
        next_cur.filt[i] = nf;
        // Only enabled input pins raise events
        ev = cur.pin_direction[i] & cur.input_irq_enable[i];
        if (cur.rising_edge_select[i] == cur.falling_edge_select[i]) begin
          ev = ev & (nf != cur.filt[i]);
        end else if (cur.rising_edge_select[i]) begin
          ev = ev & nf & ~cur.filt[i];
        end else begin
          ev = ev & ~nf & cur.filt[i];
        end
        // Return to the last-read level clears only with no select
        clr = pin_rd | (~cur.rising_edge_select[i] &
               ~cur.falling_edge_select[i] & (nf == cur.snap[i]));
        if (ev) begin
          next_cur.irq_status[i] = 1'b1; // Set wins over clear
        end else if (clr) begin
          next_cur.irq_status[i] = 1'b0;
        end
      end

      // Reset pin: defaults once held low long enough
      if (cur.rstp_s[1]) begin
        next_cur.rcnt = 2'h0;
      end else if (cur.rcnt != gpx_pkg::RST_PIN_LAST) begin
        next_cur.rcnt = cur.rcnt + 2'h1;
      end else begin
        next_cur = defaults(next_cur);
      end
    end
    if (rst) begin
      next_cur = defaults(next_cur);
      next_cur.sclk_s = 2'h0;
      next_cur.cs_s = 2'h3;
      next_cur.mosi_s = 2'h0;
      next_cur.rstp_s = 2'h3;
      next_cur.in_s1 = 8'h00;
      next_cur.in_s2 = 8'h00;
      next_cur.sclk_d = 1'b0;
      next_cur.shift = 8'h00;
      next_cur.rd = 1'b0;
      next_cur.addr = 6'h00;
      next_cur.rcnt = 2'h0;
      next_cur.filt = 8'h00;
      next_cur.cnt = '0;
      next_cur.snap = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  // Pins drive only as outputs not in high impedance
  assign gpio_out = cur.output_level;
  assign gpio_oe = ~cur.pin_direction & ~cur.output_hiz_enable;
  assign pullup_en = cur.pullup_enable;
  assign link.miso = cur.miso;
  assign link.irq_oe = |cur.irq_status;

endmodule // gpx_device
`default_nettype wire

// ===== verilog/gpx_host.sv
`timescale 1ns/100ps
`default_nettype none
// Serial master: one command byte and one data byte per request
module gpx_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  gpx_link_if.host link,
  input wire logic start, // Request pulse, taken when not busy
  input wire logic rd, // Read when high
  input wire logic [5:0] addr, // Register offset
  input wire logic [7:0] wdata, // Write data
  input wire logic pin_reset, // Hold device reset pin low
  output logic busy, // Access in progress
  output logic done, // One-cycle end of access
  output logic [7:0] rdata, // Data taken in the last access, zero after a write
  output logic irq // Device interrupt pending
);

  // Master sequence
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_LOW,
    HS_HIGH,
    HS_END
  } hstate_t;

  // Whole state of the master
  typedef struct packed {
    hstate_t st;
    logic [3:0] tick; // Half-period counter
    logic [4:0] bitn; // Bits sent so far
    logic [15:0] sr; // Command and data, MSB first
    logic [7:0] rx; // Bits taken from the device
    logic [1:0] miso_s; // Synchroniser, [0] first stage
    logic [1:0] irq_s;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic rst_n;
    logic done;
    logic [7:0] rdata;
  } hstate_all_t;

  hstate_all_t cur; // Registered state
  hstate_all_t next_cur; // Next state

  // Next-state logic
  always_comb begin
    logic half; // Half period over
    next_cur = cur;
    half = cur.tick == gpx_pkg::SCLK_HALF_LAST;
    if (ce) begin
      next_cur.miso_s = {cur.miso_s[0], link.miso};
      next_cur.irq_s = {cur.irq_s[0], ~link.irq_n};
      next_cur.rst_n = ~pin_reset;
      next_cur.done = 1'b0;
      next_cur.tick = half ? 4'h0 : cur.tick + 4'h1;
      case (cur.st)
        HS_IDLE: begin
          next_cur.tick = 4'h0;
          if (start) begin
            // Bit 0 of the command is left zero
            next_cur.sr = {rd, addr, 1'b0, rd ? 8'h00 : wdata};
            next_cur.cs_n = 1'b0;
            next_cur.st = HS_SETUP;
          end
        end
        HS_SETUP: begin
          // Select settles for a half period before the first bit
          if (half) begin
            next_cur.mosi = cur.sr[15];
            next_cur.bitn = 5'h00;
            next_cur.st = HS_LOW;
          end
        end
        HS_LOW: begin
          if (half) begin
            next_cur.sclk = 1'b1;
            next_cur.st = HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (half) begin
            // Sample late in the high phase; the device shifts after fall
            next_cur.rx = {cur.rx[6:0], cur.miso_s[1]};
            next_cur.sclk = 1'b0;
            next_cur.sr = {cur.sr[14:0], 1'b0};
            next_cur.mosi = cur.sr[14];
            next_cur.bitn = cur.bitn + 5'h01;
            next_cur.st = (cur.bitn + 5'h01 == gpx_pkg::BITS_ALL) ?
                          HS_END : HS_LOW;
          end
        end
        HS_END: begin
          if (half) begin
            next_cur.cs_n = 1'b1;
            next_cur.mosi = 1'b0;
            next_cur.rdata = cur.rx;
            next_cur.done = 1'b1;
            next_cur.st = HS_IDLE;
          end
        end
        default: next_cur.st = HS_IDLE;
      endcase
    end
    if (rst) begin
      next_cur.st = HS_IDLE;
      next_cur.tick = 4'h0;
      next_cur.bitn = 5'h00;
      next_cur.sr = 16'h0000;
      next_cur.rx = 8'h00;
      next_cur.miso_s = 2'h0;
      next_cur.irq_s = 2'h0;
      next_cur.sclk = 1'b0;
      next_cur.cs_n = 1'b1;
      next_cur.mosi = 1'b0;
      next_cur.rst_n = 1'b1;
      next_cur.done = 1'b0;
      next_cur.rdata = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  assign link.sclk = cur.sclk;
  assign link.cs_n = cur.cs_n;
  assign link.mosi = cur.mosi;
  assign link.reset_n = cur.rst_n;
  assign busy = cur.st != HS_IDLE;
  assign done = cur.done;
  assign rdata = cur.rdata;
  assign irq = cur.irq_s[1];

endmodule // gpx_host
`default_nettype wire

// ===== testbench/gpx_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the shared wires: framing, clock shape, reset pin
module gpx_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic reset_n,
  input wire logic irq_oe,
  input wire logic irq_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [4:0] rises; // Clock rises seen in the current frame

  // Restart the count at each select, so aborted frames cannot leak
  always_ff @(posedge clk) begin
    if (rst || $fell(cs_n)) begin
      rises <= 5'h00;
    end else if ($rose(sclk)) begin
      rises <= rises + 5'h01;
    end
  end

  sclk_idle_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  select_first_a: assert property ($rose(sclk) |-> !$past(cs_n, 4))
    else $error("clock rose too soon after select");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  frame_len_a: assert property ($fell(cs_n) |-> ##136 $rose(cs_n))
    else $error("frame length wrong");
  rise_count_a: assert property ($rose(cs_n) |-> rises == 5'h10)
    else $error("frame without sixteen clock rises");
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("master data moved while clock high");
  miso_hold_a: assert property (sclk |-> $stable(miso))
    else $error("device data moved while clock high");
  pin_reset_a: assert property (!reset_n [*8] |-> ##[0:4] !irq_oe)
    else $error("interrupt held through reset pin");
  irq_level_a: assert property (irq_oe |-> !irq_n)
    else $error("interrupt line not pulled low");

  frame_c: cover property ($rose(cs_n));
  irq_c: cover property ($rose(irq_oe));
  pin_reset_c: cover property (!reset_n [*8]);
endmodule // gpx_assertions
`default_nettype wire

// ===== testbench/spi_gpio_expander_8bit_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Host and expander back to back, driven from the host request port
module spi_gpio_expander_8bit_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic rd = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic pin_reset = 1'b0;
  logic [7:0] gpio_in = 8'h00; // Pin levels seen by the expander
  logic busy, done, irq;
  logic [7:0] rdata, gpio_out, gpio_oe, pullup_en;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0; // Hang guard
  gpx_link_if link ();

  gpx_device u_gpx_device (.clk(clk), .rst(rst), .ce(1'b1), .link(link),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pullup_en(pullup_en));
  gpx_host u_gpx_host (.clk(clk), .rst(rst), .ce(1'b1), .link(link),
    .start(start), .rd(rd), .addr(addr), .wdata(wdata),
    .pin_reset(pin_reset), .busy(busy), .done(done), .rdata(rdata),
    .irq(irq));
  gpx_assertions u_gpx_assertions (.clk(clk), .rst(rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .reset_n(link.reset_n), .irq_oe(link.irq_oe),
    .irq_n(link.irq_n));

  // 50 MHz clock
  always #10 clk = ~clk;

  // Ceiling well above the roughly 13000 cycles the run needs
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One access; done is sampled on the falling edge, clear of updates.
  // Returns on a rising edge so that callers drive inputs on it.
  task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check({7'h00, busy}, 8'h01);
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n = n + 1;
    end
    if (n == 300) begin
      err_total = err_total + 1;
      $display("ERROR t=%0t access hung, done %h", $time, done);
    end
    check({7'h00, busy}, 8'h00);
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    acc(1'b1, a, 8'h00);
    check(rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Defaults, write-back, read-only place, unmapped place, reset pin
  task automatic t_regs();
    logic [7:0] dflt [11];
    dflt = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hFF};
    check(gpio_oe, 8'h00);
    for (int i = 1; i < 11; i++) begin
      rdchk(6'(i), dflt[i]);
      acc(1'b0, 6'(i), 8'h5A ^ 8'(i));
      rdchk(6'(i), (i == 7) ? 8'h00 : 8'h5A ^ 8'(i));
    end
    acc(1'b0, 6'h0B, 8'h33);
    rdchk(6'h0B, 8'h00);
    check(gpio_out, 8'h5B);
    check(pullup_en, 8'h5E);
    check(gpio_oe, 8'hA2);
    pin_reset <= 1'b1;
    idle(10);
    pin_reset <= 1'b0;
    idle(10);
    rdchk(6'h01, 8'hFF);
    rdchk(6'h03, 8'hFF);
    check(gpio_oe, 8'h00);
  endtask

  // Mixed directions: outputs show the latch, inputs the pins, two of them inverted
  task automatic t_pin();
    acc(1'b0, 6'h03, 8'h0F);
    acc(1'b0, 6'h01, 8'hA5);
    // Inversion set on two inputs and on two outputs, which ignore it
    acc(1'b0, 6'h02, 8'h36);
    gpio_in <= 8'h5C;
    idle(10);
    rdchk(6'h00, 8'hAA);
  endtask

  // Every edge-select mode, then output pin, disabled pin and filter
  task automatic t_irq();
    logic [1:0] m; // Bit 0 rising select, bit 1 falling select
    acc(1'b0, 6'h03, 8'hFF);
    acc(1'b0, 6'h02, 8'h00);
    acc(1'b0, 6'h0A, 8'h00);
    acc(1'b0, 6'h05, 8'h01);
    gpio_in <= 8'h00;
    idle(10);
    acc(1'b1, 6'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      acc(1'b0, 6'h08, {7'h00, m[0]});
      acc(1'b0, 6'h09, {7'h00, m[1]});
      acc(1'b1, 6'h00, 8'h00);
      gpio_in <= 8'h01;
      idle(10);
      rdchk(6'h07, {7'h00, m != 2'b10});
      check({7'h00, irq}, {7'h00, m != 2'b10});
      acc(1'b1, 6'h00, 8'h00);
      gpio_in <= 8'h00;
      idle(10);
      rdchk(6'h07, {7'h00, m != 2'b01});
      acc(1'b1, 6'h00, 8'h00);
      rdchk(6'h07, 8'h00);
    end
    // No edge select: a return to the last-read level clears
    acc(1'b0, 6'h08, 8'h00);
    acc(1'b0, 6'h09, 8'h00);
    acc(1'b1, 6'h00, 8'h00);
    gpio_in <= 8'h01;
    idle(10);
    rdchk(6'h07, 8'h01);
    gpio_in <= 8'h00;
    idle(10);
    rdchk(6'h07, 8'h00);
    check({7'h00, irq}, 8'h00);
    acc(1'b0, 6'h03, 8'hFE);
    gpio_in <= 8'h01;
    idle(10);
    rdchk(6'h07, 8'h00);
    gpio_in <= 8'h00;
    acc(1'b0, 6'h03, 8'hFF);
    acc(1'b0, 6'h05, 8'h00);
    gpio_in <= 8'h01;
    idle(10);
    rdchk(6'h07, 8'h00);
    gpio_in <= 8'h00;
    acc(1'b0, 6'h05, 8'h01);
    acc(1'b0, 6'h0A, 8'h01);
    acc(1'b1, 6'h00, 8'h00);
    gpio_in <= 8'h01;
    idle(8);
    gpio_in <= 8'h00;
    idle(70);
    rdchk(6'h07, 8'h00);
    gpio_in <= 8'h01;
    idle(70);
    rdchk(6'h07, 8'h01);
  endtask

  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    idle(4);
    t_regs();
    t_pin();
    t_irq();
    final_report();
  end
endmodule // spi_gpio_expander_8bit_tb
`default_nettype wire
